// *** psfr_bank.sv ***
// psfr_bank: ahb-lite special function register bank with port, pointer and flag registers
// assumes a single ahb-lite master, word transfers, pins asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none

module psfr_bank #(
    parameter int PTR_W = 8
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [7:0]            port_b_inputs,
    output logic      [7:0]            port_b_outputs,
    output logic      [7:0]            port_b_direction,
    input  wire psfr_pkg::psfr_events_t hw_events,
    output logic      [PTR_W-1:0]      scratch_addr,
    output logic                       scratch_we,
    output logic      [7:0]            scratch_wdata,
    input  wire logic [7:0]            scratch_rdata,
    output logic                       irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]            pin_meta;
    logic [7:0]            pin_sync;
    logic [7:0]            output_port_latch;
    logic [7:0]            direction_select;
    logic [PTR_W-1:0]      scratch_pointer;
    logic [7:0]            system_flag_byte;
    logic [7:0]            infrared_result;
    logic [2:0]            irq_status;
    logic [2:0]            irq_enable;
    psfr_pkg::psfr_req_t   dreq;
    logic                  wr_go;
    logic                  rd_go;
    logic [7:0]            wbyte;
    logic [7:0]            next_flags;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // ----------------------------------------------------------------
    // bus address phase capture
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dreq <= '0;
        end
        else if (hready)
        begin
            dreq.valid <= hsel && htrans[1];
            dreq.write <= hwrite;
            dreq.addr  <= haddr[7:0];
        end
    end

    // zero-wait slave: reads are combinational from registers and scratch_rdata, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_go     = dreq.valid && dreq.write;
    assign rd_go     = dreq.valid && !dreq.write;
    assign wbyte     = hwdata[7:0];

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end
        else
        begin
            pin_meta <= port_b_inputs;
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------------------------------
    // output latch and direction
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            output_port_latch <= psfr_pkg::RST_OUTPUT_LATCH;
        end
        else if (wr_go && (hit(dreq.addr, psfr_pkg::OFF_OUTPUT_PORT_LATCH)
                           || hit(dreq.addr, psfr_pkg::OFF_PORT_ALIAS)))
        begin
            // a port alias write carries whatever software read, so
            // read-then-write copies the sampled inputs out
            output_port_latch <= wbyte & psfr_pkg::OUTPUT_IMPL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            direction_select <= psfr_pkg::RST_DIRECTION;
        end
        else if (wr_go && hit(dreq.addr, psfr_pkg::OFF_DIRECTION_SELECT))
        begin
            direction_select <= wbyte & psfr_pkg::DIR_IMPL_MASK;
        end
    end

    assign port_b_outputs   = output_port_latch;
    assign port_b_direction = direction_select;

    // ----------------------------------------------------------------
    // scratch pointer with post increment and decrement
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scratch_pointer <= PTR_W'(psfr_pkg::RST_POINTER);
        end
        else if (wr_go && hit(dreq.addr, psfr_pkg::OFF_SCRATCH_POINTER))
        begin
            scratch_pointer <= PTR_W'(hwdata);
        end
        else if (dreq.valid && hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA_INC))
        begin
            scratch_pointer <= scratch_pointer + PTR_W'(1);
        end
        else if (dreq.valid && hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA_DEC))
        begin
            scratch_pointer <= scratch_pointer - PTR_W'(1);
        end
    end

    // memory sees the pointer before it moves: access then step
    assign scratch_addr  = scratch_pointer;
    assign scratch_wdata = wbyte;
    assign scratch_we    = wr_go && (hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA)
                                     || hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA_INC)
                                     || hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA_DEC));

    // ----------------------------------------------------------------
    // system flag byte
    // ----------------------------------------------------------------
    always_comb
    begin
        next_flags = system_flag_byte;
        if (wr_go && hit(dreq.addr, psfr_pkg::OFF_SYSTEM_FLAG_BYTE))
        begin
            next_flags = wbyte;
        end
        // low five bits have no event source; events override a clearing write
        if (hw_events.ser_rx)
        begin
            next_flags[psfr_pkg::FLAG_SER_BIT] = 1'b1;
        end
        if (hw_events.i2c_wr)
        begin
            next_flags[psfr_pkg::FLAG_I2C_BIT] = 1'b1;
        end
        if (hw_events.tmr_ovf)
        begin
            next_flags[psfr_pkg::FLAG_TMR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            system_flag_byte <= psfr_pkg::RST_FLAGS;
        end
        else
        begin
            system_flag_byte <= next_flags;
        end
    end

    // infrared result is a byte register of its own, read and written by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            infrared_result <= psfr_pkg::RST_INFRARED;
        end
        else if (wr_go && hit(dreq.addr, psfr_pkg::OFF_INFRARED_RESULT))
        begin
            infrared_result <= wbyte;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, enable and clear
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status <= psfr_pkg::RST_IRQ;
            irq_enable <= psfr_pkg::RST_IRQ;
        end
        else
        begin
            if (wr_go && hit(dreq.addr, psfr_pkg::OFF_IRQ_ENABLE))
            begin
                irq_enable <= wbyte[2:0];
            end
            // set wins over a same-cycle clear
            irq_status <= (irq_status & ~((wr_go && hit(dreq.addr, psfr_pkg::OFF_IRQ_CLEAR))
                                          ? wbyte[2:0] : 3'h0))
                          | {hw_events.tmr_ovf, hw_events.i2c_wr, hw_events.ser_rx};
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (rd_go)
        begin
            case (dreq.addr)
                psfr_pkg::OFF_INPUT_PORT_VALUE,
                psfr_pkg::OFF_PORT_ALIAS:
                    hrdata[7:0] = pin_sync & psfr_pkg::INPUT_IMPL_MASK;
                psfr_pkg::OFF_DIRECTION_SELECT: hrdata[7:0] = direction_select;
                psfr_pkg::OFF_SCRATCH_POINTER:  hrdata[PTR_W-1:0] = scratch_pointer;
                psfr_pkg::OFF_SCRATCH_DATA,
                psfr_pkg::OFF_SCRATCH_DATA_INC,
                psfr_pkg::OFF_SCRATCH_DATA_DEC: hrdata[7:0] = scratch_rdata;
                psfr_pkg::OFF_SYSTEM_FLAG_BYTE: hrdata[7:0] = system_flag_byte;
                psfr_pkg::OFF_INFRARED_RESULT:  hrdata[7:0] = infrared_result;
                psfr_pkg::OFF_IRQ_STATUS:       hrdata[2:0] = irq_status;
                psfr_pkg::OFF_IRQ_ENABLE:       hrdata[2:0] = irq_enable;
                default:                        hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // writes land one edge after the data phase, so $past sees the written word
    sequence s_flag_write_zero;
        wr_go && hit(dreq.addr, psfr_pkg::OFF_SYSTEM_FLAG_BYTE) && !wbyte[7];
    endsequence

    sequence s_dir_write;
        wr_go && hit(dreq.addr, psfr_pkg::OFF_DIRECTION_SELECT);
    endsequence

    a_out_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        port_b_outputs[7:6] == 2'h0)
        else $error("output bits 7:6 set");
    a_dir_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (direction_select & ~psfr_pkg::DIR_IMPL_MASK) == 8'h00)
        else $error("unimplemented direction bit set");
    a_dir_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
        s_dir_write |=> direction_select == ($past(wbyte) & psfr_pkg::DIR_IMPL_MASK))
        else $error("direction write not stored");
    a_out_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_go && hit(dreq.addr, psfr_pkg::OFF_OUTPUT_PORT_LATCH)
        |=> port_b_outputs == ($past(wbyte) & psfr_pkg::OUTPUT_IMPL_MASK))
        else $error("port write not driven");
    a_ptr_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_go && hit(dreq.addr, psfr_pkg::OFF_SCRATCH_POINTER)
        |=> scratch_pointer == PTR_W'($past(hwdata)))
        else $error("pointer write not stored");
    a_ptr_inc_step: assert property (@(posedge hclk) disable iff (!hresetn)
        dreq.valid && hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA_INC)
        |=> scratch_pointer == $past(scratch_pointer) + PTR_W'(1))
        else $error("post increment wrong");
    a_ptr_dec_step: assert property (@(posedge hclk) disable iff (!hresetn)
        dreq.valid && hit(dreq.addr, psfr_pkg::OFF_SCRATCH_DATA_DEC)
        |=> scratch_pointer == $past(scratch_pointer) - PTR_W'(1))
        else $error("post decrement wrong");
    a_ser_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_events.ser_rx |=> system_flag_byte[psfr_pkg::FLAG_SER_BIT])
        else $error("serial flag lost");
    a_tmr_flag_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_events.tmr_ovf |=> system_flag_byte[psfr_pkg::FLAG_TMR_BIT])
        else $error("timer flag lost");
    a_i2c_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_events.i2c_wr |=> system_flag_byte[psfr_pkg::FLAG_I2C_BIT])
        else $error("i2c flag lost");
    a_tmr_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        system_flag_byte[psfr_pkg::FLAG_TMR_BIT]
        && !(wr_go && hit(dreq.addr, psfr_pkg::OFF_SYSTEM_FLAG_BYTE))
        |=> system_flag_byte[psfr_pkg::FLAG_TMR_BIT])
        else $error("timer flag dropped without a write");
    a_low_flags_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr_go && hit(dreq.addr, psfr_pkg::OFF_SYSTEM_FLAG_BYTE))
        |=> system_flag_byte[4:0] == 5'($past(system_flag_byte)))
        else $error("low flag bits changed without a write");
    a_flag_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        s_flag_write_zero ##0 !hw_events.tmr_ovf |=> !system_flag_byte[7])
        else $error("flag clear ignored");
    a_irq_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_events.tmr_ovf |=> irq_status[2])
        else $error("timer status lost");
    a_port_read_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_go && hit(dreq.addr, psfr_pkg::OFF_INPUT_PORT_VALUE)
        |-> hrdata[7:0] == (pin_sync & psfr_pkg::INPUT_IMPL_MASK) && hrdata[5:3] == 3'h0)
        else $error("port read wrong");

endmodule : psfr_bank

`default_nettype wire

// *** psfr_board.sv ***
// psfr_board: board model, drives the port pins and holds the scratchpad memory
// assumes a combinational scratch read and a scratch write on the rising edge
`timescale 1ns/1ps
`default_nettype none

module psfr_board (
    input  wire logic       hclk,
    input  wire logic [7:0] pin_level,
    input  wire logic [7:0] scratch_addr,
    input  wire logic       scratch_we,
    input  wire logic [7:0] scratch_wdata,
    output logic      [7:0] port_b_inputs,
    output logic      [7:0] scratch_rdata
);
    // ----------------------------------------------------------------
    // pins and memory
    // ----------------------------------------------------------------
    logic [7:0] mem [256];

    // pins move off the core edge: a board is unrelated in phase
    assign #1.3 port_b_inputs = pin_level;
    assign scratch_rdata = mem[scratch_addr];

    // one process owns the memory, seeded with a pattern, not unknowns
    always @(posedge hclk or negedge hclk)
    begin
        if (mem[0] === 8'hxx)
            for (int k = 0; k < 256; k++)
                mem[k] = 8'(k) ^ 8'h96;
        else if (hclk && scratch_we)
            mem[scratch_addr] <= scratch_wdata;
    end
endmodule : psfr_board

`default_nettype wire

// *** psfr_pkg.sv ***
// psfr_pkg: register map, field positions, reset values and carrier types of the port sfr bank
// assumes a 32-bit ahb-lite slave, one word per register, byte-wide data in the low bits
package psfr_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_INPUT_PORT_VALUE   = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_PORT_LATCH  = 8'h04;
    localparam logic [7:0] OFF_DIRECTION_SELECT   = 8'h08;
    localparam logic [7:0] OFF_SCRATCH_POINTER    = 8'h0c;
    localparam logic [7:0] OFF_SCRATCH_DATA       = 8'h10;
    localparam logic [7:0] OFF_SCRATCH_DATA_INC   = 8'h14;
    localparam logic [7:0] OFF_SCRATCH_DATA_DEC   = 8'h18;
    localparam logic [7:0] OFF_SYSTEM_FLAG_BYTE   = 8'h1c;
    localparam logic [7:0] OFF_PORT_ALIAS         = 8'h20;
    localparam logic [7:0] OFF_INFRARED_RESULT    = 8'h24;
    localparam logic [7:0] OFF_IRQ_STATUS         = 8'h28;
    localparam logic [7:0] OFF_IRQ_ENABLE         = 8'h2c;
    localparam logic [7:0] OFF_IRQ_CLEAR          = 8'h30;

    // ----------------------------------------------------------------
    // implemented bit masks and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] INPUT_IMPL_MASK  = 8'hc7;
    localparam logic [7:0] OUTPUT_IMPL_MASK = 8'h3f;
    localparam logic [7:0] DIR_IMPL_MASK    = 8'h16;
    localparam int         FLAG_SER_BIT     = 5;
    localparam int         FLAG_I2C_BIT     = 6;
    localparam int         FLAG_TMR_BIT     = 7;
    localparam logic [7:0] FLAG_HW_MASK     = 8'he0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION    = 8'h00;
    localparam logic [7:0] RST_POINTER      = 8'h00;
    localparam logic [7:0] RST_FLAGS        = 8'h00;
    localparam logic [7:0] RST_INFRARED     = 8'h00;
    localparam logic [2:0] RST_IRQ          = 3'h0;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } psfr_req_t;

    typedef struct packed {
        logic ser_rx;
        logic i2c_wr;
        logic tmr_ovf;
    } psfr_events_t;

endpackage : psfr_pkg

// *** tb_port_sfr_bank.sv ***
// tb_port_sfr_bank: self-checking bench for the port sfr bank
// assumes psfr_pkg, psfr_bank and psfr_board are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_port_sfr_bank;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                   hclk = 1'b0;
    logic                   hresetn, hsel, hwrite, hreadyout, hresp, scratch_we, irq;
    logic [31:0]            haddr, hwdata, hrdata, rd;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic [7:0]             pins, outs, dirs, saddr, swd, srd, pin_level, v;
    psfr_pkg::psfr_events_t hw_events;
    int                     miscompares = 0;
    int                     n_tests = 0;

    psfr_bank #(.PTR_W(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_b_inputs(pins), .port_b_outputs(outs), .port_b_direction(dirs),
        .hw_events(hw_events), .scratch_addr(saddr), .scratch_we(scratch_we),
        .scratch_wdata(swd), .scratch_rdata(srd), .irq(irq));
    psfr_board board (.hclk(hclk), .pin_level(pin_level), .scratch_addr(saddr),
        .scratch_we(scratch_we), .scratch_wdata(swd), .port_b_inputs(pins),
        .scratch_rdata(srd));

    always #2.5 hclk = ~hclk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] w32(input logic [7:0] x, input logic [7:0] m);
        return {24'h0, x & m};
    endfunction : w32

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // one single transfer; leaves 1 ns after the data-phase edge so outputs settle
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
        #1;
    endtask : bus

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 8'h00, r);
        check(what, r, e);
    endtask : rdchk

    // write through an alias at p, then read back through it; pointer must land on e
    task automatic step(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
        logic [31:0] r;
        logic [7:0]  d;
        d = 8'($urandom);
        bus(psfr_pkg::OFF_SCRATCH_POINTER, 1'b1, p, r);
        bus(a, 1'b1, d, r);
        check("scratch mem", {24'h0, board.mem[p]}, {24'h0, d});
        rdchk("pointer", psfr_pkg::OFF_SCRATCH_POINTER, {24'h0, e});
        bus(psfr_pkg::OFF_SCRATCH_POINTER, 1'b1, p, r);
        rdchk("scratch read", a, {24'h0, d});
        rdchk("pointer", psfr_pkg::OFF_SCRATCH_POINTER, {24'h0, e});
    endtask : step

    // ----------------------------------------------------------------
    // watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        #100000;
        miscompares++;
        final_report();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        hw_events = '0;
        pin_level = 8'h00;
        v = 8'($urandom(32'h7a5b));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(psfr_pkg::OFF_OUTPUT_PORT_LATCH, 1'b1, 8'hc3, rd);
        check("outputs", {24'h0, outs}, 32'h03);
        for (int i = 0; i < 8; i++)
        begin
            bus(psfr_pkg::OFF_DIRECTION_SELECT, 1'b1, 8'h01 << i, rd);
            check("dir bit", {24'h0, dirs}, w32(8'h01 << i, 8'h16));
        end
        for (int i = 0; i < 20; i++)
        begin
            v = 8'($urandom);
            pin_level <= v ^ 8'h5a;
            bus(psfr_pkg::OFF_OUTPUT_PORT_LATCH, 1'b1, v, rd);
            check("outputs", {24'h0, outs}, w32(v, 8'h3f));
            bus(psfr_pkg::OFF_DIRECTION_SELECT, 1'b1, v, rd);
            check("direction", {24'h0, dirs}, w32(v, 8'h16));
            rdchk("direction rd", psfr_pkg::OFF_DIRECTION_SELECT, w32(v, 8'h16));
            rdchk("inputs", psfr_pkg::OFF_INPUT_PORT_VALUE, w32(v ^ 8'h5a, 8'hc7));
            bus(psfr_pkg::OFF_SCRATCH_POINTER, 1'b1, v, rd);
            rdchk("pointer", psfr_pkg::OFF_SCRATCH_POINTER, w32(v, 8'hff));
            bus(psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 1'b1, v, rd);
            rdchk("flags", psfr_pkg::OFF_SYSTEM_FLAG_BYTE, w32(v, 8'hff));
            bus(psfr_pkg::OFF_INFRARED_RESULT, 1'b1, ~v, rd);
            rdchk("infrared", psfr_pkg::OFF_INFRARED_RESULT, w32(~v, 8'hff));
        end
        // read the alias then write the value back: inputs copied to outputs
        pin_level <= 8'ha5;
        repeat (4) @(posedge hclk);
        bus(psfr_pkg::OFF_PORT_ALIAS, 1'b0, 8'h00, rd);
        check("alias read", rd, w32(8'ha5, 8'hc7));
        bus(psfr_pkg::OFF_PORT_ALIAS, 1'b1, rd[7:0], rd);
        check("alias copy", {24'h0, outs}, w32(8'ha5 & 8'hc7, 8'h3f));
        step(psfr_pkg::OFF_SCRATCH_DATA_INC, 8'hff, 8'h00);
        step(psfr_pkg::OFF_SCRATCH_DATA_DEC, 8'h00, 8'hff);
        step(psfr_pkg::OFF_SCRATCH_DATA_INC, v, v + 8'h01);
        step(psfr_pkg::OFF_SCRATCH_DATA_DEC, v, v - 8'h01);
        step(psfr_pkg::OFF_SCRATCH_DATA, v, v);
        for (int i = 0; i < 3; i++)
        begin
            bus(psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 1'b1, 8'h00, rd);
            bus(psfr_pkg::OFF_IRQ_ENABLE, 1'b1, 8'h00, rd);
            hw_events <= 3'b001 << i;
            @(posedge hclk);
            hw_events <= '0;
            repeat (3) @(posedge hclk);
            #1;
            check("irq masked", {31'h0, irq}, 32'h0);
            rdchk("flags ev", psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 32'h80 >> i);
            rdchk("irq status", psfr_pkg::OFF_IRQ_STATUS, 32'h04 >> i);
            bus(psfr_pkg::OFF_IRQ_ENABLE, 1'b1, 8'h07, rd);
            check("irq on", {31'h0, irq}, 32'h1);
            bus(psfr_pkg::OFF_IRQ_CLEAR, 1'b1, 8'h04 >> i, rd);
            check("irq clear", {31'h0, irq}, 32'h0);
            bus(psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 1'b1, 8'h00, rd);
            rdchk("flags clr", psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 32'h0);
        end
        // an overflow in the very cycle of a clearing write must survive it
        fork
            bus(psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 1'b1, 8'h00, rd);
            begin
                @(posedge hclk);
                hw_events <= 3'b001;
                @(posedge hclk);
                hw_events <= '0;
            end
        join
        rdchk("flags race", psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 32'h80);
        // a reset in mid-run returns every register to zero
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("outputs rst", {24'h0, outs}, 32'h0);
        check("dir rst", {24'h0, dirs}, 32'h0);
        rdchk("pointer rst", psfr_pkg::OFF_SCRATCH_POINTER, 32'h0);
        rdchk("flags rst", psfr_pkg::OFF_SYSTEM_FLAG_BYTE, 32'h0);
        bus(8'h3c, 1'b1, 8'hff, rd);
        rdchk("unmapped", 8'h3c, 32'h0);
        final_report();
    end
endmodule : tb_port_sfr_bank

`default_nettype wire
